//--- src/ncrb_regs.vh
// Register numbers, field positions and reset values of the node register bank
`ifndef NCRB_REGS_VH
`define NCRB_REGS_VH

// ----------------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------------
`define NCRB_REG_NODE_IDENTIFICATION 8'h00
`define NCRB_REG_SWITCH_TOPOLOGY 8'h01
`define NCRB_REG_SWITCH_LOCK_HDR 8'h04
`define NCRB_REG_NODE_NUMBER 8'h05
`define NCRB_REG_PLL_MULT_DIV 8'h06
`define NCRB_REG_SWITCH_CLK_RATIO 8'h07
`define NCRB_REG_REF_CLK_RATIO 8'h08
`define NCRB_REG_TEST_PART_CODE 8'h09
`define NCRB_REG_TEST_USER_CODE 8'h0A
`define NCRB_REG_ROUTE_DIRS_LOW 8'h0C
`define NCRB_REG_ROUTE_DIRS_HIGH 8'h0D
`define NCRB_REG_DEBUG_PIN_TILE0 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NCRB_LOCK_CTRL_BIT 31
`define NCRB_LOCK_PLL_BIT 8
`define NCRB_HDR_ONE_BYTE_BIT 0
`define NCRB_PLL_NO_RESET_BIT 31
`define NCRB_PLL_NO_RELOCK_WAIT_BIT 30
`define NCRB_PLL_BYPASS_BIT 29
`define NCRB_PLL_TAP_BOOT_BIT 28
`define NCRB_PLL_OD_HI 25
`define NCRB_PLL_OD_LO 23
`define NCRB_PLL_F_HI 20
`define NCRB_PLL_F_LO 8
`define NCRB_PLL_R_HI 6
`define NCRB_PLL_R_LO 0
`define NCRB_DBG_REQ_EN_BIT 1
`define NCRB_DBG_DRIVE_EN_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define NCRB_RST_SWITCH_CLK_RATIO 16'h0000
`define NCRB_RST_REF_CLK_RATIO 16'h0003
`define NCRB_RST_NODE_NUMBER 16'h0000
`define NCRB_RST_PLL_SETTINGS 32'h00000000

`endif

//--- src/ncrb_node_config_register_bank.v
// Node configuration register bank with packet direction lookup
`timescale 1ns/1ns
`default_nettype none
`include "ncrb_regs.vh"

module ncrb_node_config_register_bank #(
	parameter [7:0] SWITCH_REVISION = 8'h01,
	parameter [7:0] SWITCH_VERSION = 8'h01,
	parameter [7:0] NUM_SERIAL_LINKS = 8'h08,
	parameter [7:0] NUM_SWITCH_PROCS = 8'h02,
	parameter [7:0] NUM_DEVICE_PROCS = 8'h02,
	// Arbitrary neutral value
	parameter [31:0] PART_CODE = 32'h00000001,
	// Arbitrary neutral value
	parameter [17:0] FIXABLE_ID_CODE = 18'h00001
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_b,
	// Configuration access
	input wire i_cfg_wr,
	input wire i_cfg_rd,
	input wire [7:0] i_cfg_num,
	input wire [31:0] i_cfg_wdata,
	output reg [31:0] o_cfg_rdata,
	output reg o_cfg_rvalid,
	output reg o_cfg_wr_refused,
	// Straps and fuses
	input wire [7:0] i_boot_control_pins,
	input wire [13:0] i_otp_user_code,
	// PLL and clock control
	output wire [2:0] o_pll_output_divider,
	output wire [12:0] o_pll_feedback_mult,
	output wire [6:0] o_pll_input_divider,
	output wire o_pll_bypass,
	output wire o_boot_from_test_port,
	output wire o_pll_no_relock_wait,
	output reg o_pll_update,
	output reg o_tile_reset,
	output wire [15:0] o_switch_clock_ratio,
	output wire [15:0] o_reference_clock_ratio,
	output wire o_one_byte_headers,
	// Packet routing
	input wire [15:0] i_route_dest,
	output reg [3:0] o_route_dir,
	output reg o_route_local,
	// Debug coupling for tile 0
	input wire i_global_debug_line,
	input wire i_core_in_debug,
	output reg o_debug_request,
	output reg o_global_debug_drive
);

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	reg [7:0] boot_pins_reg;
	reg boot_caught_reg;
	reg lock_ctrl_reg;
	reg lock_pll_reg;
	reg one_byte_hdr_reg;
	reg [15:0] node_number_reg;
	reg [31:0] pll_settings_reg;
	reg [15:0] switch_clk_ratio_reg;
	reg [15:0] ref_clk_ratio_reg;
	reg [31:0] route_dirs_low_reg;
	reg [31:0] route_dirs_high_reg;
	reg dbg_req_en_reg;
	reg dbg_drive_en_reg;
	wire [63:0] dirs_all;
	wire is_pll;
	wire is_lock;
	wire write_ok;
	reg hit_ident;
	reg hit_topo;
	reg hit_node;
	reg hit_sw_clk;
	reg hit_ref_clk;
	reg hit_part;
	reg hit_user;
	reg hit_dirs_low;
	reg hit_dirs_high;
	reg hit_debug;
	reg [31:0] rdata_next;

	// ------------------------------------------------------------------
	// Register number decode
	// ------------------------------------------------------------------
	always @*
	begin
		hit_ident = 1'b0;
		hit_topo = 1'b0;
		hit_node = 1'b0;
		hit_sw_clk = 1'b0;
		hit_ref_clk = 1'b0;
		hit_part = 1'b0;
		hit_user = 1'b0;
		hit_dirs_low = 1'b0;
		hit_dirs_high = 1'b0;
		hit_debug = 1'b0;
		if (i_cfg_num == `NCRB_REG_NODE_IDENTIFICATION)
			hit_ident = 1'b1;
		else if (i_cfg_num == `NCRB_REG_SWITCH_TOPOLOGY)
			hit_topo = 1'b1;
		else if (i_cfg_num == `NCRB_REG_NODE_NUMBER)
			hit_node = 1'b1;
		else if (i_cfg_num == `NCRB_REG_SWITCH_CLK_RATIO)
			hit_sw_clk = 1'b1;
		else if (i_cfg_num == `NCRB_REG_REF_CLK_RATIO)
			hit_ref_clk = 1'b1;
		else if (i_cfg_num == `NCRB_REG_TEST_PART_CODE)
			hit_part = 1'b1;
		else if (i_cfg_num == `NCRB_REG_TEST_USER_CODE)
			hit_user = 1'b1;
		else if (i_cfg_num == `NCRB_REG_ROUTE_DIRS_LOW)
			hit_dirs_low = 1'b1;
		else if (i_cfg_num == `NCRB_REG_ROUTE_DIRS_HIGH)
			hit_dirs_high = 1'b1;
		else if (i_cfg_num == `NCRB_REG_DEBUG_PIN_TILE0)
			hit_debug = 1'b1;
	end

	assign dirs_all = {route_dirs_high_reg, route_dirs_low_reg};
	assign is_pll = (i_cfg_num == `NCRB_REG_PLL_MULT_DIV);
	assign is_lock = (i_cfg_num == `NCRB_REG_SWITCH_LOCK_HDR);
	// Lock register itself stays writable so software can release locks
	assign write_ok = is_pll ? ~lock_pll_reg :
		(is_lock | ~lock_ctrl_reg);

	// ------------------------------------------------------------------
	// Boot pin capture
	// ------------------------------------------------------------------
	// Pins caught once, first clock after reset release
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			boot_caught_reg <= 1'b0;
			boot_pins_reg <= 8'h00;
		end
		else if (!boot_caught_reg)
		begin
			boot_pins_reg <= i_boot_control_pins;
			boot_caught_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			lock_ctrl_reg <= 1'b0;
			lock_pll_reg <= 1'b0;
			one_byte_hdr_reg <= 1'b0;
			node_number_reg <= `NCRB_RST_NODE_NUMBER;
			pll_settings_reg <= `NCRB_RST_PLL_SETTINGS;
			switch_clk_ratio_reg <= `NCRB_RST_SWITCH_CLK_RATIO;
			ref_clk_ratio_reg <= `NCRB_RST_REF_CLK_RATIO;
			route_dirs_low_reg <= 32'h00000000;
			route_dirs_high_reg <= 32'h00000000;
			dbg_req_en_reg <= 1'b0;
			dbg_drive_en_reg <= 1'b0;
			o_pll_update <= 1'b0;
			o_tile_reset <= 1'b0;
			o_cfg_wr_refused <= 1'b0;
		end
		else
		begin
			o_pll_update <= 1'b0;
			o_tile_reset <= 1'b0;
			o_cfg_wr_refused <= i_cfg_wr & ~write_ok;
			if (i_cfg_wr && write_ok)
			begin
				if (is_lock)
				begin
					lock_ctrl_reg <= i_cfg_wdata[`NCRB_LOCK_CTRL_BIT];
					lock_pll_reg <= i_cfg_wdata[`NCRB_LOCK_PLL_BIT];
					one_byte_hdr_reg <= i_cfg_wdata[`NCRB_HDR_ONE_BYTE_BIT];
				end
				else if (i_cfg_num == `NCRB_REG_NODE_NUMBER)
				begin
					node_number_reg <= i_cfg_wdata[15:0];
				end
				else if (is_pll)
				begin
					// Reserved bits 27:26, 22:21 and 7 dropped
					pll_settings_reg <= i_cfg_wdata & 32'hF39FFF7F;
					o_pll_update <= 1'b1;
					o_tile_reset <= ~i_cfg_wdata[`NCRB_PLL_NO_RESET_BIT];
				end
				else if (i_cfg_num == `NCRB_REG_SWITCH_CLK_RATIO)
				begin
					switch_clk_ratio_reg <= i_cfg_wdata[15:0];
				end
				else if (i_cfg_num == `NCRB_REG_REF_CLK_RATIO)
				begin
					ref_clk_ratio_reg <= i_cfg_wdata[15:0];
				end
				else if (i_cfg_num == `NCRB_REG_ROUTE_DIRS_LOW)
				begin
					route_dirs_low_reg <= i_cfg_wdata;
				end
				else if (i_cfg_num == `NCRB_REG_ROUTE_DIRS_HIGH)
				begin
					route_dirs_high_reg <= i_cfg_wdata;
				end
				else if (i_cfg_num == `NCRB_REG_DEBUG_PIN_TILE0)
				begin
					dbg_req_en_reg <= i_cfg_wdata[`NCRB_DBG_REQ_EN_BIT];
					dbg_drive_en_reg <= i_cfg_wdata[`NCRB_DBG_DRIVE_EN_BIT];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	always @*
	begin
		rdata_next = 32'h00000000;
		if (hit_ident)
			rdata_next = {8'h00, boot_pins_reg, SWITCH_REVISION,
				SWITCH_VERSION};
		else if (hit_topo)
			rdata_next = {8'h00, NUM_SERIAL_LINKS, NUM_SWITCH_PROCS,
				NUM_DEVICE_PROCS};
		else if (is_lock)
			rdata_next = {lock_ctrl_reg, 22'h000000, lock_pll_reg,
				7'h00, one_byte_hdr_reg};
		else if (hit_node)
			rdata_next = {16'h0000, node_number_reg};
		else if (is_pll)
			rdata_next = pll_settings_reg;
		else if (hit_sw_clk)
			rdata_next = {16'h0000, switch_clk_ratio_reg};
		else if (hit_ref_clk)
			rdata_next = {16'h0000, ref_clk_ratio_reg};
		else if (hit_part)
			rdata_next = PART_CODE;
		else if (hit_user)
			rdata_next = {i_otp_user_code, FIXABLE_ID_CODE};
		else if (hit_dirs_low)
			rdata_next = route_dirs_low_reg;
		else if (hit_dirs_high)
			rdata_next = route_dirs_high_reg;
		else if (hit_debug)
			rdata_next = {30'h0000000, dbg_req_en_reg, dbg_drive_en_reg};
	end

	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_cfg_rdata <= 32'h00000000;
			o_cfg_rvalid <= 1'b0;
		end
		else
		begin
			o_cfg_rvalid <= i_cfg_rd;
			if (i_cfg_rd)
				o_cfg_rdata <= rdata_next;
		end
	end

	// ------------------------------------------------------------------
	// Routing lookup
	// ------------------------------------------------------------------
	wire [15:0] mismatch;
	wire [15:0] higher_diff;
	wire [15:0] top_diff;
	wire [3:0] dir_pick [0:15];
	reg [3:0] dir_next;
	integer k;
	genvar g;

	assign mismatch = i_route_dest ^ node_number_reg;

	// Per dimension: flag the most significant differing bit and pass
	// only its direction nibble, so at most one nibble is non-zero
	generate
		for (g = 0; g < 16; g = g + 1)
		begin : g_dim
			if (g == 15)
			begin : g_msb
				assign higher_diff[g] = 1'b0;
			end
			else
			begin : g_rest
				assign higher_diff[g] = higher_diff[g + 1] | mismatch[g + 1];
			end
			assign top_diff[g] = mismatch[g] & ~higher_diff[g];
			assign dir_pick[g] = top_diff[g] ?
				dirs_all[4 * g + 3:4 * g] : 4'h0;
		end
	endgenerate

	// Local delivery shows the dimension 0 entry
	always @*
	begin
		dir_next = (mismatch == 16'h0000) ? dirs_all[3:0] : 4'h0;
		for (k = 0; k < 16; k = k + 1)
			dir_next = dir_next | dir_pick[k];
	end

	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_route_dir <= 4'h0;
			o_route_local <= 1'b0;
		end
		else
		begin
			o_route_dir <= dir_next;
			o_route_local <= (mismatch == 16'h0000);
		end
	end

	// ------------------------------------------------------------------
	// Debug line coupling for tile 0
	// ------------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_debug_request <= 1'b0;
			o_global_debug_drive <= 1'b0;
		end
		else
		begin
			o_debug_request <= dbg_req_en_reg &
				i_global_debug_line;
			o_global_debug_drive <= dbg_drive_en_reg &
				i_core_in_debug;
		end
	end

	// ------------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------------
	assign o_pll_output_divider =
		pll_settings_reg[`NCRB_PLL_OD_HI:`NCRB_PLL_OD_LO];
	assign o_pll_feedback_mult =
		pll_settings_reg[`NCRB_PLL_F_HI:`NCRB_PLL_F_LO];
	assign o_pll_input_divider =
		pll_settings_reg[`NCRB_PLL_R_HI:`NCRB_PLL_R_LO];
	assign o_pll_bypass = pll_settings_reg[`NCRB_PLL_BYPASS_BIT];
	assign o_boot_from_test_port =
		pll_settings_reg[`NCRB_PLL_TAP_BOOT_BIT];
	assign o_pll_no_relock_wait =
		pll_settings_reg[`NCRB_PLL_NO_RELOCK_WAIT_BIT];
	assign o_switch_clock_ratio = switch_clk_ratio_reg;
	assign o_reference_clock_ratio = ref_clk_ratio_reg;
	assign o_one_byte_headers = one_byte_hdr_reg;

endmodule

`default_nettype wire

//--- dv/ncrb_node_config_register_bank_properties.sv
// Concurrent checks on the node register bank ports
`timescale 1ns/1ns
`default_nettype none
module ncrb_node_config_register_bank_properties (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Configuration access
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_num,
	input wire logic [31:0] i_cfg_wdata,
	input wire logic o_cfg_rvalid,
	input wire logic o_cfg_wr_refused,
	// Controls
	input wire logic [2:0] o_pll_output_divider,
	input wire logic [12:0] o_pll_feedback_mult,
	input wire logic [6:0] o_pll_input_divider,
	input wire logic o_pll_bypass,
	input wire logic o_pll_update,
	input wire logic o_tile_reset,
	input wire logic [15:0] o_reference_clock_ratio,
	input wire logic i_global_debug_line,
	input wire logic o_debug_request
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_rd_answer;
		##1 o_cfg_rvalid;
	endsequence
	sequence s_pll_write;
		i_cfg_wr && i_cfg_num == 8'h06;
	endsequence
	a_read_answered: assert property (i_cfg_rd |-> s_rd_answer)
		else $error("read without answer");
	a_refusal_cause: assert property (o_cfg_wr_refused |->
		$past(i_cfg_wr && i_cfg_num != 8'h04))
		else $error("refusal without write");
	a_pll_update_cause: assert property (o_pll_update |->
		$past(i_cfg_wr && i_cfg_num == 8'h06))
		else $error("pll update without write");
	a_tile_reset_cause: assert property (s_pll_write ##1 o_tile_reset |->
		$past(!i_cfg_wdata[31]))
		else $error("tile reset despite no-reset bit");
	a_pll_fields_load: assert property (s_pll_write ##1 o_pll_update |->
		o_pll_feedback_mult == $past(i_cfg_wdata[20:8])
		&& o_pll_output_divider == $past(i_cfg_wdata[25:23])
		&& o_pll_input_divider == $past(i_cfg_wdata[6:0]))
		else $error("pll fields differ from write");
	a_pll_bypass_load: assert property (o_pll_update |->
		o_pll_bypass == $past(i_cfg_wdata[29]))
		else $error("bypass differs from write");
	a_debug_req_cause: assert property (o_debug_request |->
		$past(i_global_debug_line))
		else $error("debug request without line");
	a_ref_ratio_hold: assert property (!(i_cfg_wr && i_cfg_num == 8'h08)
		|=> $stable(o_reference_clock_ratio))
		else $error("reference ratio changed unwritten");
endmodule
bind ncrb_node_config_register_bank ncrb_node_config_register_bank_properties
	i_props (.i_clk, .i_rst_b, .i_cfg_wr, .i_cfg_rd, .i_cfg_num,
	.i_cfg_wdata, .o_cfg_rvalid, .o_cfg_wr_refused, .o_pll_output_divider,
	.o_pll_feedback_mult, .o_pll_input_divider, .o_pll_bypass,
	.o_pll_update, .o_tile_reset, .o_reference_clock_ratio,
	.i_global_debug_line, .o_debug_request);
`default_nettype wire

//--- dv/ncrb_node_config_register_bank_tb.sv
// Self-checking testbench for the node register bank
`timescale 1ns/1ns
`default_nettype none
module ncrb_node_config_register_bank_tb;
	logic clk, rst_b, wr, rd, gdl, cid, rv, rf, upd, trst, hdr, loc;
	logic dreq, gdrv, tap, nrw;
	logic [7:0] num;
	logic [31:0] wd, rdat;
	logic [15:0] dest, refr, swr;
	logic [3:0] dir;
	int n_errors, tests_run;
	ncrb_node_config_register_bank i_dut (
		.i_clk(clk), .i_rst_b(rst_b), .i_cfg_wr(wr), .i_cfg_rd(rd),
		.i_cfg_num(num), .i_cfg_wdata(wd), .o_cfg_rdata(rdat),
		.o_cfg_rvalid(rv), .o_cfg_wr_refused(rf),
		.i_boot_control_pins(8'hA5), .i_otp_user_code(14'h2A5A),
		.o_pll_output_divider(), .o_pll_feedback_mult(),
		.o_pll_input_divider(), .o_pll_bypass(),
		.o_boot_from_test_port(tap), .o_pll_no_relock_wait(nrw),
		.o_pll_update(upd), .o_tile_reset(trst),
		.o_switch_clock_ratio(swr), .o_reference_clock_ratio(refr),
		.o_one_byte_headers(hdr), .i_route_dest(dest), .o_route_dir(dir),
		.o_route_local(loc), .i_global_debug_line(gdl),
		.i_core_in_debug(cid), .o_debug_request(dreq),
		.o_global_debug_drive(gdrv));
	// ------------------------------------------------------------------
	// Check and bus tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [7:0] n, input logic [31:0] d);
		@(negedge clk);
		wr = 1'b1;
		num = n;
		wd = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] n, input logic [31:0] e);
		@(negedge clk);
		rd = 1'b1;
		num = n;
		@(negedge clk);
		rd = 1'b0;
		chk({31'h0, rv}, 32'h1);
		chk(rdat, e);
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] z [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D,
			8'h10, 8'h02};
		rreg(8'h00, 32'h00A50101);
		rreg(8'h01, 32'h00080202);
		rreg(8'h0A, 32'hA9680001);
		rreg(8'h08, 32'h3);
		chk({16'h0, refr}, 32'h3);
		foreach (z[i]) rreg(z[i], 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_rw;
		logic [7:0] n [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h0C, 8'h0D, 8'h10};
		logic [31:0] m [7] = '{32'hFFFF, 32'hF39FFF7F, 32'hFFFF, 32'hFFFF,
			32'hFFFFFFFF, 32'hFFFFFFFF, 32'h3};
		wreg(8'h04, 32'hFFFFFFFF);
		rreg(8'h04, 32'h80000101);
		chk({31'h0, hdr}, 32'h1);
		wreg(8'h04, 32'h0);
		wreg(8'h00, 32'hFFFFFFFF);
		rreg(8'h00, 32'h00A50101);
		wreg(8'h02, 32'hFFFFFFFF);
		rreg(8'h02, 32'h0);
		foreach (n[i])
		begin
			wreg(n[i], 32'hFFFFFFFF);
			rreg(n[i], m[i]);
		end
		chk({14'h0, nrw, tap, swr}, 32'h3FFFF);
		$display("t_rw done");
	endtask
	task automatic t_lock;
		wreg(8'h04, 32'h80000100);
		wreg(8'h05, 32'h1234);
		chk({31'h0, rf}, 32'h1);
		wreg(8'h06, 32'h0);
		chk({31'h0, rf}, 32'h1);
		rreg(8'h05, 32'hFFFF);
		rreg(8'h06, 32'hF39FFF7F);
		wreg(8'h04, 32'h0);
		wreg(8'h05, 32'h00F0);
		chk({31'h0, rf}, 32'h0);
		rreg(8'h05, 32'h00F0);
		wreg(8'h06, 32'h0);
		chk({30'h0, upd, trst}, 32'h3);
		wreg(8'h06, 32'h80000000);
		chk({30'h0, upd, trst}, 32'h2);
		$display("t_lock done");
	endtask
	task automatic t_route;
		wreg(8'h0C, 32'h76543210);
		wreg(8'h0D, 32'hFEDCBA98);
		for (int k = 0; k < 16; k++)
		begin
			dest = 16'h00F0 ^ (16'hFFFF >> (15 - k));
			@(negedge clk);
			chk({27'h0, loc, dir}, k);
		end
		dest = 16'h00F0;
		@(negedge clk);
		chk({27'h0, loc, dir}, 32'h10);
		$display("t_route done");
	endtask
	task automatic t_debug;
		wreg(8'h10, 32'h0);
		gdl = 1'b1;
		cid = 1'b1;
		@(negedge clk);
		chk({30'h0, dreq, gdrv}, 32'h0);
		wreg(8'h10, 32'h2);
		@(negedge clk);
		chk({30'h0, dreq, gdrv}, 32'h2);
		wreg(8'h10, 32'h1);
		@(negedge clk);
		chk({30'h0, dreq, gdrv}, 32'h1);
		$display("t_debug done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		#200000;
		n_errors++;
		report_and_stop;
	end
	initial
	begin
		{rst_b, wr, rd, gdl, cid, num, wd, dest} = '0;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		t_reset;
		t_rw;
		t_lock;
		t_route;
		t_debug;
		report_and_stop;
	end
endmodule
`default_nettype wire
